// ==== hdl/fbpeq_band_slice.v ====
`timescale 1ns/1ps
`default_nettype none
`include "fbpeq_defines.vh"
// ----------------------------------------
// one band: filter section plus gain mix
// ----------------------------------------
module fbpeq_band_slice #(
  parameter W  = 24,
  parameter CW = 16,
  parameter GW = 18
) (
  input  wire signed [W-1:0]  x,
  input  wire signed [W-1:0]  x1,
  input  wire signed [W-1:0]  x2,
  input  wire signed [W-1:0]  f1,
  input  wire signed [W-1:0]  f2,
  input  wire signed [CW-1:0] k,
  input  wire signed [CW-1:0] a1,
  input  wire signed [CW-1:0] a2,
  input  wire        [1:0]    kind,
  input  wire signed [GW-1:0] gain_m1,
  output wire signed [W-1:0]  f,
  output wire signed [W-1:0]  y,
  output wire                 sat
);
  localparam AW = W + CW + 4;
  function fits;
    input [AW-1:0] v;
    begin
      fits = (&v[AW-1:W-1]) | ~(|v[AW-1:W-1]);
    end
  endfunction
  function [W-1:0] clip;
    input [AW-1:0] v;
    begin
      if (fits(v))
        clip = v[W-1:0];
      else
        clip = {v[AW-1], {(W-1){~v[AW-1]}}};
    end
  endfunction
  wire signed [CW:0]   kx   = {k[CW-1], k};
  wire signed [CW:0]   nk   = -kx;
  wire signed [CW:0]   zk   = {(CW+1){1'b0}};
  // shelves: one pole; peaks: band-pass with zeros at dc and nyquist
  wire signed [CW:0]   b1   = (kind == `FBPEQ_KIND_HIGH) ? nk : zk;
  wire signed [CW:0]   b2   = (kind == `FBPEQ_KIND_PEAK) ? nk : zk;
  wire signed [AW-1:0] acc  = x * kx + x1 * b1 + x2 * b2 - f1 * a1 - f2 * a2;
  wire signed [AW-1:0] fw   = acc >>> `FBPEQ_FRAC;
  wire signed [AW-1:0] prod = f * gain_m1;
  wire signed [AW-1:0] yw   = x + (prod >>> `FBPEQ_FRAC);
  assign f   = clip(fw);
  assign y   = clip(yw);
  assign sat = ~fits(fw) | ~fits(yw);
endmodule // fbpeq_band_slice
`default_nettype wire

// ==== hdl/fbpeq_defines.vh ====
`ifndef FBPEQ_DEFINES_VH
`define FBPEQ_DEFINES_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define FBPEQ_AW            8
`define FBPEQ_DW            16
`define FBPEQ_EN_ADDR       8'h86
`define FBPEQ_B1_ADDR       8'h87
`define FBPEQ_B2_ADDR       8'h88
`define FBPEQ_B3_ADDR       8'h89
`define FBPEQ_B4_ADDR       8'h8A
`define FBPEQ_B5_ADDR       8'h8B
`define FBPEQ_COEF_FIRST    8'h8C
`define FBPEQ_COEF_LAST     8'h9D
`define FBPEQ_MODE_ADDR     8'h9E
`define FBPEQ_STAT_ADDR     8'h9F
// ----------------------------------------
// field positions
// ----------------------------------------
`define FBPEQ_EN_BIT        0
`define FBPEQ_MODE_BIT      0
`define FBPEQ_GAIN_MSB      4
`define FBPEQ_BUSY_BIT      0
`define FBPEQ_RUNON_BIT     1
`define FBPEQ_RUNMODE_BIT   2
`define FBPEQ_RSVD_BIT      3
`define FBPEQ_SAT_BIT       4
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define FBPEQ_EN_RST        1'b0
`define FBPEQ_MODE_RST      1'b0
`define FBPEQ_GAIN_RST      5'h0C
`define FBPEQ_GAIN_MAX      5'h18
// ----------------------------------------
// datapath
// ----------------------------------------
`define FBPEQ_BANDS         3'h5
`define FBPEQ_LAST_BAND     3'h4
`define FBPEQ_NCOEF         18
`define FBPEQ_FRAC          14
`define FBPEQ_KIND_LOW      2'h0
`define FBPEQ_KIND_PEAK     2'h1
`define FBPEQ_KIND_HIGH     2'h2
// ----------------------------------------
// built-in coefficients, q2.14
// ----------------------------------------
`define FBPEQ_B1_K          16'h00D5
`define FBPEQ_B1_A1         16'hC0D5
`define FBPEQ_B2_K          16'h013B
`define FBPEQ_B2_A1         16'h8296
`define FBPEQ_B2_A2         16'h3D89
`define FBPEQ_B3_K          16'h0377
`define FBPEQ_B3_A1         16'h87EA
`define FBPEQ_B3_A2         16'h3913
`define FBPEQ_B4_K          16'h08A1
`define FBPEQ_B4_A1         16'h97F6
`define FBPEQ_B4_A2         16'h2EBF
`define FBPEQ_B5_K          16'h2CF9
`define FBPEQ_B5_A1         16'hE610
`define FBPEQ_ZERO_COEF     16'h0000
`endif

// ==== hdl/fbpeq_gain_lut.v ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// gain code to linear gain minus one
// ----------------------------------------
module fbpeq_gain_lut (
  input  wire        [4:0]  code,
  output reg  signed [17:0] gain_m1
);
  always @* begin
    case (code)
      5'h00: gain_m1 = 18'h3D014;
      5'h01: gain_m1 = 18'h3D209;
      5'h02: gain_m1 = 18'h3D43D;
      5'h03: gain_m1 = 18'h3D6B6;
      5'h04: gain_m1 = 18'h3D97B;
      5'h05: gain_m1 = 18'h3DC97;
      5'h06: gain_m1 = 18'h3E014;
      5'h07: gain_m1 = 18'h3E3FD;
      5'h08: gain_m1 = 18'h3E862;
      5'h09: gain_m1 = 18'h3ED4E;
      5'h0A: gain_m1 = 18'h3F2D6;
      5'h0B: gain_m1 = 18'h3F90B;
      5'h0C: gain_m1 = 18'h00000;
      5'h0D: gain_m1 = 18'h007CF;
      5'h0E: gain_m1 = 18'h01092;
      5'h0F: gain_m1 = 18'h01A66;
      5'h10: gain_m1 = 18'h02570;
      5'h11: gain_m1 = 18'h031D0;
      5'h12: gain_m1 = 18'h03FB3;
      5'h13: gain_m1 = 18'h04F47;
      5'h14: gain_m1 = 18'h060C2;
      5'h15: gain_m1 = 18'h07460;
      5'h16: gain_m1 = 18'h08A62;
      5'h17: gain_m1 = 18'h0A313;
      5'h18: gain_m1 = 18'h0BECB;
      // reserved codes act as 0 dB
      default: gain_m1 = 18'h00000;
    endcase
  end
endmodule // fbpeq_gain_lut
`default_nettype wire

// ==== hdl/fbpeq_top.v ====
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "fbpeq_defines.vh"
module fbpeq_top #(
  parameter W  = 24,
  parameter CW = 16,
  parameter GW = 18
) (
  input  wire                 clk,
  input  wire                 rst_n,
  input  wire                 ce,
  input  wire [`FBPEQ_AW-1:0] addr,
  input  wire [`FBPEQ_DW-1:0] wdata,
  input  wire                 wr,
  input  wire                 rd,
  output reg  [`FBPEQ_DW-1:0] rdata,
  input  wire                 in_valid,
  output wire                 in_ready,
  input  wire [W-1:0]         in_left,
  input  wire [W-1:0]         in_right,
  output wire                 out_valid,
  output reg  [W-1:0]         out_left,
  output reg  [W-1:0]         out_right
);
  localparam integer NB    = `FBPEQ_BANDS;
  localparam integer NS    = 2 * NB;
  localparam integer NC    = `FBPEQ_NCOEF;
  localparam [2:0]   ST_IDLE = 3'h1;
  localparam [2:0]   ST_RUN  = 3'h2;
  localparam [2:0]   ST_OUT  = 3'h4;
  integer i;
  integer j;

  // ----------------------------------------
  // address decoding
  // ----------------------------------------
  function is_gain;
    input [`FBPEQ_AW-1:0] a;
    begin
      is_gain = (a >= `FBPEQ_B1_ADDR) && (a <= `FBPEQ_B5_ADDR);
    end
  endfunction

  function is_coef;
    input [`FBPEQ_AW-1:0] a;
    begin
      is_coef = (a >= `FBPEQ_COEF_FIRST) && (a <= `FBPEQ_COEF_LAST);
    end
  endfunction

  // built-in set; normalised to fs, so band edges track the rate
  function [CW-1:0] fixed_coef;
    input [4:0] idx;
    begin
      case (idx)
        5'h00:   fixed_coef = `FBPEQ_B1_K;
        5'h01:   fixed_coef = `FBPEQ_B1_A1;
        5'h03:   fixed_coef = `FBPEQ_B2_K;
        5'h04:   fixed_coef = `FBPEQ_B2_A1;
        5'h05:   fixed_coef = `FBPEQ_B2_A2;
        5'h06:   fixed_coef = `FBPEQ_B3_K;
        5'h07:   fixed_coef = `FBPEQ_B3_A1;
        5'h08:   fixed_coef = `FBPEQ_B3_A2;
        5'h09:   fixed_coef = `FBPEQ_B4_K;
        5'h0A:   fixed_coef = `FBPEQ_B4_A1;
        5'h0B:   fixed_coef = `FBPEQ_B4_A2;
        5'h0C:   fixed_coef = `FBPEQ_B5_K;
        5'h0D:   fixed_coef = `FBPEQ_B5_A1;
        default: fixed_coef = `FBPEQ_ZERO_COEF;
      endcase
    end
  endfunction

  // shelf at each end, peaks between
  function [1:0] band_kind;
    input [2:0] b;
    begin
      case (b)
        3'h0:             band_kind = `FBPEQ_KIND_LOW;
        `FBPEQ_LAST_BAND: band_kind = `FBPEQ_KIND_HIGH;
        default:          band_kind = `FBPEQ_KIND_PEAK;
      endcase
    end
  endfunction

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  reg                 equaliser_on;
  reg                 user_coefficient_mode;
  reg  [4:0]          level [0:NB-1];
  reg  [CW-1:0]       coef  [0:NC-1];
  reg                 sat_seen;
  wire [4:0]          low_shelf_level  = level[0];
  wire [4:0]          peak_two_level   = level[1];
  wire [4:0]          peak_three_level = level[2];
  wire [4:0]          peak_four_level  = level[3];
  wire [4:0]          high_shelf_level = level[4];
  wire [`FBPEQ_AW-1:0] gidx = addr - `FBPEQ_B1_ADDR;
  wire [`FBPEQ_AW-1:0] cidx = addr - `FBPEQ_COEF_FIRST;

  always @(posedge clk) begin
    if (!rst_n) begin
      equaliser_on          <= `FBPEQ_EN_RST;
      user_coefficient_mode <= `FBPEQ_MODE_RST;
      for (j = 0; j < NB; j = j + 1)
        level[j] <= `FBPEQ_GAIN_RST;
      for (j = 0; j < NC; j = j + 1)
        coef[j] <= fixed_coef(j[4:0]);
    end else if (ce && wr) begin
      if (addr == `FBPEQ_EN_ADDR)
        equaliser_on <= wdata[`FBPEQ_EN_BIT];
      if (addr == `FBPEQ_MODE_ADDR)
        user_coefficient_mode <= wdata[`FBPEQ_MODE_BIT];
      if (is_gain(addr))
        level[gidx[2:0]] <= wdata[`FBPEQ_GAIN_MSB:0];
      if (is_coef(addr))
        coef[cidx[4:0]] <= wdata;
    end
  end

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  reg  [2:0]          state;
  reg                 ch;
  reg  [2:0]          band;
  reg  signed [W-1:0] cur;
  reg  [W-1:0]        hold_r;
  reg                 run_on;
  reg                 run_mode;
  reg  signed [W-1:0] hx1 [0:NS-1];
  reg  signed [W-1:0] hx2 [0:NS-1];
  reg  signed [W-1:0] hf1 [0:NS-1];
  reg  signed [W-1:0] hf2 [0:NS-1];

  // ----------------------------------------
  // status
  // ----------------------------------------
  wire [NB-1:0] rsvd_vec;
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : g_rsvd
      assign rsvd_vec[g] = level[g] > `FBPEQ_GAIN_MAX;
    end
  endgenerate
  wire busy = (state != ST_IDLE);

  // ----------------------------------------
  // register read, data valid one cycle on
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      rdata <= {`FBPEQ_DW{1'b0}};
    end else if (ce) begin
      rdata <= {`FBPEQ_DW{1'b0}};
      if (rd) begin
        case (addr)
          `FBPEQ_EN_ADDR:
            rdata[`FBPEQ_EN_BIT] <= equaliser_on;
          `FBPEQ_B1_ADDR:
            rdata[`FBPEQ_GAIN_MSB:0] <= low_shelf_level;
          `FBPEQ_B2_ADDR:
            rdata[`FBPEQ_GAIN_MSB:0] <= peak_two_level;
          `FBPEQ_B3_ADDR:
            rdata[`FBPEQ_GAIN_MSB:0] <= peak_three_level;
          `FBPEQ_B4_ADDR:
            rdata[`FBPEQ_GAIN_MSB:0] <= peak_four_level;
          `FBPEQ_B5_ADDR:
            rdata[`FBPEQ_GAIN_MSB:0] <= high_shelf_level;
          `FBPEQ_MODE_ADDR:
            rdata[`FBPEQ_MODE_BIT] <= user_coefficient_mode;
          `FBPEQ_STAT_ADDR: begin
            rdata[`FBPEQ_BUSY_BIT]    <= busy;
            rdata[`FBPEQ_RUNON_BIT]   <= run_on;
            rdata[`FBPEQ_RUNMODE_BIT] <= run_mode;
            rdata[`FBPEQ_RSVD_BIT]    <= |rsvd_vec;
            rdata[`FBPEQ_SAT_BIT]     <= sat_seen;
          end
          default: begin
            if (is_coef(addr))
              rdata <= coef[cidx[4:0]];
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // coefficient and gain selection
  // ----------------------------------------
  wire [3:0] slot  = {1'b0, band} + (ch ? {1'b0, `FBPEQ_BANDS} : 4'h0);
  wire [4:0] cbase = {1'b0, band, 1'b0} + {2'b00, band};
  wire [4:0] ci_a1 = cbase + 5'h01;
  wire [4:0] ci_a2 = cbase + 5'h02;
  // user set from registers, built-in set otherwise
  wire [CW-1:0] sel_k  = run_mode ? coef[cbase] : fixed_coef(cbase);
  wire [CW-1:0] sel_a1 = run_mode ? coef[ci_a1] : fixed_coef(ci_a1);
  wire [CW-1:0] sel_a2 = run_mode ? coef[ci_a2] : fixed_coef(ci_a2);
  wire [1:0] kind = band_kind(band);

  wire signed [GW-1:0] gain_m1;
  wire signed [W-1:0]  band_f;
  wire signed [W-1:0]  band_y;
  wire                 band_sat;

  // gains feed the slice the same way in either mode
  fbpeq_gain_lut u_gain (
    .code    (level[band]),
    .gain_m1 (gain_m1)
  );

  fbpeq_band_slice #(
    .W  (W),
    .CW (CW),
    .GW (GW)
  ) u_slice (
    .x       (cur),
    .x1      (hx1[slot]),
    .x2      (hx2[slot]),
    .f1      (hf1[slot]),
    .f2      (hf2[slot]),
    .k       (sel_k),
    .a1      (sel_a1),
    .a2      (sel_a2),
    .kind    (kind),
    .gain_m1 (gain_m1),
    .f       (band_f),
    .y       (band_y),
    .sat     (band_sat)
  );

  // ----------------------------------------
  // sample sequencer
  // ----------------------------------------
  assign in_ready  = ce & (state == ST_IDLE);
  assign out_valid = ce & (state == ST_OUT);

  always @(posedge clk) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      ch        <= 1'b0;
      band      <= 3'h0;
      cur       <= {W{1'b0}};
      hold_r    <= {W{1'b0}};
      run_on    <= 1'b0;
      run_mode  <= 1'b0;
      out_left  <= {W{1'b0}};
      out_right <= {W{1'b0}};
      for (i = 0; i < NS; i = i + 1) begin
        hx1[i] <= {W{1'b0}};
        hx2[i] <= {W{1'b0}};
        hf1[i] <= {W{1'b0}};
        hf2[i] <= {W{1'b0}};
      end
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          // stale history would ring after enable or mode change
          if (!equaliser_on || (user_coefficient_mode != run_mode)) begin
            for (i = 0; i < NS; i = i + 1) begin
              hx1[i] <= {W{1'b0}};
              hx2[i] <= {W{1'b0}};
              hf1[i] <= {W{1'b0}};
              hf2[i] <= {W{1'b0}};
            end
          end
          if (in_valid) begin
            run_on   <= equaliser_on;
            run_mode <= user_coefficient_mode;
            ch       <= 1'b0;
            band     <= 3'h0;
            if (equaliser_on) begin
              cur    <= in_left;
              hold_r <= in_right;
              state  <= ST_RUN;
            end else begin
              out_left  <= in_left;
              out_right <= in_right;
              state     <= ST_OUT;
            end
          end
        end
        ST_RUN: begin
          hx2[slot] <= hx1[slot];
          hx1[slot] <= cur;
          hf2[slot] <= hf1[slot];
          hf1[slot] <= band_f;
          if (band == `FBPEQ_LAST_BAND) begin
            band <= 3'h0;
            if (!ch) begin
              out_left <= band_y;
              cur      <= hold_r;
              ch       <= 1'b1;
            end else begin
              out_right <= band_y;
              state     <= ST_OUT;
            end
          end else begin
            band <= band + 3'h1;
            cur  <= band_y;
          end
        end
        ST_OUT: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // sticky saturation flag, set beats clear
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      sat_seen <= 1'b0;
    end else if (ce) begin
      if (wr && (addr == `FBPEQ_STAT_ADDR) && wdata[`FBPEQ_SAT_BIT])
        sat_seen <= 1'b0;
      if ((state == ST_RUN) && band_sat)
        sat_seen <= 1'b1;
    end
  end
endmodule // fbpeq_top
`default_nettype wire

// ==== verif/fbpeq_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fbpeq_defines.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module fbpeq_chk #(
  parameter W = 24
) (
  input wire logic         clk,
  input wire logic         rst_n,
  input wire logic         ce,
  input wire logic [7:0]   addr,
  input wire logic [15:0]  wdata,
  input wire logic         wr,
  input wire logic         rd,
  input wire logic [15:0]  rdata,
  input wire logic         in_valid,
  input wire logic         in_ready,
  input wire logic [W-1:0] in_left,
  input wire logic [W-1:0] in_right,
  input wire logic         out_valid,
  input wire logic [W-1:0] out_left,
  input wire logic [W-1:0] out_right
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic en_sh;
  wire  take = in_valid && in_ready;
  // shadow of the enable bit as software last wrote it
  always @(posedge clk) begin
    if (!rst_n) en_sh <= 1'b0;
    else if (ce && wr && addr == `FBPEQ_EN_ADDR) en_sh <= wdata[0];
  end
  property p_rdata_zero;
    rdata != 16'h0000 |-> $past(rd && ce);
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside read cycle");
  property p_en_rsvd;
    rd && ce && addr == `FBPEQ_EN_ADDR |=> rdata[15:1] == 15'h0000;
  endproperty
  a_en_rsvd: assert property (p_en_rsvd) else $error("enable word upper bits set");
  property p_gain_rsvd;
    rd && ce && addr >= `FBPEQ_B1_ADDR && addr <= `FBPEQ_B5_ADDR |=> rdata[15:5] == 11'h000;
  endproperty
  a_gain_rsvd: assert property (p_gain_rsvd) else $error("gain word upper bits set");
  property p_ce_gate;
    !ce |-> !in_ready && !out_valid;
  endproperty
  a_ce_gate: assert property (p_ce_gate) else $error("stream active while frozen");
  property p_valid_pulse;
    out_valid |=> !out_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("result pulse too long");
  property p_take_busy;
    take |=> !in_ready;
  endproperty
  a_take_busy: assert property (p_take_busy) else $error("ready while busy");
  property p_bypass;
    take && !en_sh |=> out_valid && out_left == $past(in_left) && out_right == $past(in_right);
  endproperty
  a_bypass: assert property (p_bypass) else $error("disabled sample altered");
  property p_eq_latency;
    take && en_sh |=> (!out_valid)[*8] ##1 !out_valid ##1 !out_valid ##1 out_valid;
  endproperty
  a_eq_latency: assert property (p_eq_latency) else $error("equalised result timing");
  property p_ready_back;
    out_valid && ce |=> in_ready;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("not ready after result");
endmodule // fbpeq_chk
bind fbpeq_top fbpeq_chk #(.W(W)) u_fbpeq_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .in_valid(in_valid), .in_ready(in_ready),
  .in_left(in_left), .in_right(in_right), .out_valid(out_valid), .out_left(out_left),
  .out_right(out_right));
`default_nettype wire

// ==== verif/fbpeq_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// playback sample source and sink
// ----------------------------------------
module fbpeq_src #(
  parameter W = 24
) (
  input  wire logic         clk,
  input  wire logic         in_ready,
  input  wire logic         out_valid,
  input  wire logic [W-1:0] out_left,
  input  wire logic [W-1:0] out_right,
  output var  logic         in_valid,
  output var  logic [W-1:0] in_left,
  output var  logic [W-1:0] in_right
);
  logic [W-1:0] got_l;
  logic [W-1:0] got_r;
  int           lat;
  initial begin
    in_valid = 1'b0;
    in_left  = '0;
    in_right = '0;
  end
  task automatic send(input logic [W-1:0] l, input logic [W-1:0] r, input int gap);
    repeat (gap + 1) @(posedge clk);
    in_valid <= 1'b1;
    in_left  <= l;
    in_right <= r;
    lat = 0;
    @(negedge clk);
    while (in_ready !== 1'b1 && lat < 40) begin
      lat++;
      @(negedge clk);
    end
    @(posedge clk);
    in_valid <= 1'b0;
    // released lines must not look like held data
    in_left  <= ~l;
    in_right <= ~r;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (out_valid !== 1'b1 && lat < 40);
    got_l = out_left;
    got_r = out_right;
  endtask
endmodule // fbpeq_src
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fbpeq_defines.vh"
module testbench;
  localparam int W = 24;
  logic         clk         = 1'b0;
  logic         rst_n       = 1'b0;
  logic         ce          = 1'b1;
  logic [7:0]   addr        = 8'h00;
  logic [15:0]  wdata       = 16'h0000;
  logic         wr          = 1'b0;
  logic         rd          = 1'b0;
  logic [15:0]  rdata;
  logic         in_valid;
  logic         in_ready;
  logic         out_valid;
  logic [W-1:0] in_left;
  logic [W-1:0] in_right;
  logic [W-1:0] out_left;
  logic [W-1:0] out_right;
  logic [15:0]  model [0:255];
  logic [15:0]  v;
  logic [4:0]   codes [0:2] = '{5'h00, 5'h18, 5'h19};
  logic [15:0]  coef_rst [0:17] = '{`FBPEQ_B1_K, `FBPEQ_B1_A1, 16'h0000, `FBPEQ_B2_K, `FBPEQ_B2_A1,
    `FBPEQ_B2_A2, `FBPEQ_B3_K, `FBPEQ_B3_A1, `FBPEQ_B3_A2, `FBPEQ_B4_K, `FBPEQ_B4_A1, `FBPEQ_B4_A2,
    `FBPEQ_B5_K, `FBPEQ_B5_A1, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int           n_errors    = 0;
  int           checks_done = 0;
  always #2.5 clk = ~clk;
  fbpeq_top #(.W(W)) u_fbpeq_top (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .in_valid(in_valid), .in_ready(in_ready), .in_left(in_left),
    .in_right(in_right), .out_valid(out_valid), .out_left(out_left), .out_right(out_right));
  fbpeq_src #(.W(W)) u_fbpeq_src (.clk(clk), .in_ready(in_ready), .out_valid(out_valid),
    .out_left(out_left), .out_right(out_right), .in_valid(in_valid), .in_left(in_left),
    .in_right(in_right));
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a);
    rd_reg(a, v);
    chk($sformatf("reg %h", a), {16'h0000, v}, {16'h0000, model[a]});
  endtask
  function automatic logic [15:0] mask(input logic [7:0] a);
    if (a == `FBPEQ_EN_ADDR || a == `FBPEQ_MODE_ADDR) return 16'h0001;
    if (a >= `FBPEQ_B1_ADDR && a <= `FBPEQ_B5_ADDR) return 16'h001F;
    if (a >= `FBPEQ_COEF_FIRST && a <= `FBPEQ_COEF_LAST) return 16'hFFFF;
    return 16'h0000;
  endfunction
  task automatic init_model;
    for (int a = 0; a < 256; a++) model[a] = 16'h0000;
    for (int a = 0; a < 5; a++) model[8'h87 + a] = {11'h000, `FBPEQ_GAIN_RST};
    for (int a = 0; a < 18; a++) model[8'h8C + a] = coef_rst[a];
  endtask
  function automatic logic [W-1:0] rs();
    logic [31:0] r;
    r = $urandom;
    return {{(W-21){r[20]}}, r[20:0]};
  endfunction
  task automatic smp(input logic [W-1:0] l, input int lat, input logic same);
    u_fbpeq_src.send(l, ~l, $urandom_range(2));
    chk("latency", u_fbpeq_src.lat, lat);
    chk("left_kept", {31'h0, u_fbpeq_src.got_l === l}, {31'h0, same});
    chk("right_kept", {31'h0, u_fbpeq_src.got_r === ~l}, {31'h0, same});
  endtask
  initial begin
    #(20000 * 5);
    n_errors++;
    final_report();
  end
  initial begin
    void'($urandom(37733));
    init_model();
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 8'h80; a < 8'hA4; a++) if (a != 8'h9F) rd_chk(8'(a));
    for (int a = 8'h84; a < 8'hA2; a++) if (a != 8'h9F) begin
      v = $urandom;
      wr_reg(8'(a), v);
      model[a] = v & mask(8'(a));
    end
    for (int a = 8'h84; a < 8'hA2; a++) if (a != 8'h9F) rd_chk(8'(a));
    init_model();
    for (int a = 8'h86; a < 8'h9F; a++) wr_reg(8'(a), model[a]);
    ce <= 1'b0;
    wr_reg(`FBPEQ_B1_ADDR, 16'h0003);
    ce <= 1'b1;
    rd_chk(`FBPEQ_B1_ADDR);
    repeat (4) smp(rs(), 1, 1'b1);
    wr_reg(`FBPEQ_EN_ADDR, 16'h0001);
    repeat (4) smp(rs(), 11, 1'b1);
    rd_reg(`FBPEQ_STAT_ADDR, v);
    chk("run_on", {31'h0, v[1]}, 32'h1);
    for (int b = 0; b < 5; b++) begin
      wr_reg(8'(8'h87 + b), 16'h0018);
      smp(24'h100000, 11, 1'b0);
      wr_reg(8'(8'h87 + b), 16'h000C);
    end
    for (int i = 0; i < 3; i++) begin
      wr_reg(`FBPEQ_B3_ADDR, {11'h000, codes[i]});
      smp(24'h100000, 11, i == 2);
    end
    rd_reg(`FBPEQ_STAT_ADDR, v);
    chk("code_reserved", {31'h0, v[3]}, 32'h1);
    wr_reg(`FBPEQ_MODE_ADDR, 16'h0001);
    smp(rs(), 11, 1'b1);
    wr_reg(`FBPEQ_B2_ADDR, 16'h0018);
    smp(24'h100000, 11, 1'b0);
    rd_reg(`FBPEQ_STAT_ADDR, v);
    chk("user_mode", {31'h0, v[2]}, 32'h1);
    wr_reg(`FBPEQ_B2_ADDR, 16'h000C);
    wr_reg(`FBPEQ_EN_ADDR, 16'h0000);
    wr_reg(`FBPEQ_EN_ADDR, 16'h0001);
    wr_reg(`FBPEQ_B5_ADDR, 16'h0018);
    smp(24'h7FFFFF, 11, 1'b1);
    rd_reg(`FBPEQ_STAT_ADDR, v);
    chk("sat_seen", {31'h0, v[4]}, 32'h1);
    wr_reg(`FBPEQ_STAT_ADDR, 16'h0010);
    rd_reg(`FBPEQ_STAT_ADDR, v);
    chk("sat_clear", {31'h0, v[4]}, 32'h0);
    wr_reg(`FBPEQ_EN_ADDR, 16'h0000);
    smp(rs(), 1, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    init_model();
    for (int a = 8'h86; a < 8'h8C; a++) rd_chk(8'(a));
    smp(rs(), 1, 1'b1);
    final_report();
  end
endmodule // testbench
`default_nettype wire
